// File: lpp_unpacker.sv
// Lane word to RGB unpacker with frame-aligned depth select
`timescale 1ns/1ps
`default_nettype none
`include "lpp_regs.svh"
module lpp_unpacker
	import lpp_pkg::*;
#(
	parameter int FIFO_DEPTH = `LPP_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                    clk_sys_in,
	input  wire logic                    sys_rst_in,
	// Pins from the panel connector
	input  wire logic                    depth_sel_in,
	input  wire logic                    panel_logic_supply_in,
	// Lane words from the deserialiser
	input  wire logic [`LPP_WORD_W-1:0]  lane_word_in,
	input  wire logic                    pixel_valid_window_in,
	output logic                         lane_ready_out,
	// Pixel output
	output logic [`LPP_COLOR_W-1:0]      red_out,
	output logic [`LPP_COLOR_W-1:0]      grn_out,
	output logic [`LPP_COLOR_W-1:0]      blu_out,
	output logic                         pix_valid_out,
	input  wire logic                    pix_ready_in,
	output logic                         depth_deep_out
);
	localparam int CW = `LPP_COLOR_W;
	localparam logic [`LPP_BLANK_CNT_W-1:0] HB_MAX =
		`LPP_BLANK_CNT_W'(`LPP_HBLANK_MAX);

	// Pin synchronisers
	logic depth_s1;
	logic depth_s2;
	logic supply_s1;
	logic supply_s2;

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			depth_s1  <= `LPP_DEPTH_RST;
			depth_s2  <= `LPP_DEPTH_RST;
			supply_s1 <= 1'b0;
			supply_s2 <= 1'b0;
		end else begin
			depth_s1  <= depth_sel_in;
			depth_s2  <= depth_s1;
			supply_s1 <= panel_logic_supply_in;
			supply_s2 <= supply_s1;
		end
	end

	// Frame tracking from the valid window alone
	lpp_frame_t                   st;
	lpp_frame_t                   next_st;
	logic [`LPP_BLANK_CNT_W-1:0]  blank_cnt;
	logic [`LPP_BLANK_CNT_W-1:0]  next_blank_cnt;
	logic                         depth_deep;
	logic                         next_depth_deep;

	always_comb begin
		next_st         = st;
		next_blank_cnt  = blank_cnt;
		next_depth_deep = depth_deep;
		if (pixel_valid_window_in) begin
			next_st        = LPP_ST_LINE;
			next_blank_cnt = '0;
		end else begin
			if (blank_cnt < HB_MAX) begin
				next_blank_cnt = blank_cnt + 1'b1;
			end
			// Gap longer than any line blank means vertical blank
			next_st = (blank_cnt >= HB_MAX) ? LPP_ST_VBLANK : LPP_ST_HBLANK;
		end
		unique case (st)
			LPP_ST_LINE:   ;
			LPP_ST_HBLANK: ;
			LPP_ST_VBLANK: begin
				next_depth_deep = depth_s2;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			st         <= LPP_ST_VBLANK;
			blank_cnt  <= HB_MAX;
			depth_deep <= `LPP_DEPTH_RST;
		end else begin
			st         <= next_st;
			blank_cnt  <= next_blank_cnt;
			depth_deep <= next_depth_deep;
		end
	end

	// FIFO, each word tagged with the depth in force when it arrived
	lpp_stream_if #(.WIDTH(`LPP_WORD_W + 1)) wr_s ();
	lpp_stream_if #(.WIDTH(`LPP_WORD_W + 1)) rd_s ();

	// Words are dropped while the panel supply is down
	assign wr_s.valid = pixel_valid_window_in && supply_s2;
	assign wr_s.data  = {depth_deep, lane_word_in};

	lpp_fifo #(.WIDTH(`LPP_WORD_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys_in (clk_sys_in),
		.sys_rst_in (sys_rst_in),
		.wr         (wr_s),
		.rd         (rd_s)
	);

	assign lane_ready_out = wr_s.ready;

	logic                    pop;
	logic [`LPP_WORD_W-1:0]  pop_word;
	logic                    pop_deep;
	logic [CW-1:0]           next_red;
	logic [CW-1:0]           next_grn;
	logic [CW-1:0]           next_blu;
	logic                    next_pix_valid;

	assign pop_word   = rd_s.data[`LPP_WORD_W-1:0];
	assign pop_deep   = rd_s.data[`LPP_WORD_W];
	assign rd_s.ready = !pix_valid_out || pix_ready_in;
	assign pop        = rd_s.valid && rd_s.ready;

	always_comb begin
		next_red       = red_out;
		next_grn       = grn_out;
		next_blu       = blu_out;
		next_pix_valid = pix_valid_out && !pix_ready_in;
		if (pop) begin
			next_pix_valid = 1'b1;
			if (pop_deep) begin
				next_red = {pop_word[`LPP_RED_HI_LSB +: 8],
					pop_word[`LPP_RED_LO_LSB +: 2]};
				next_grn = {pop_word[`LPP_GRN_HI_LSB +: 8],
					pop_word[`LPP_GRN_LO_LSB +: 2]};
				next_blu = {pop_word[`LPP_BLU_HI_LSB +: 8],
					pop_word[`LPP_BLU_LO_LSB +: 2]};
			end else begin
				// Top bits repeated so full scale stays full scale
				next_red = {pop_word[`LPP_RED_HI_LSB +: 8],
					pop_word[`LPP_RED_HI_LSB + 6 +: 2]};
				next_grn = {pop_word[`LPP_GRN_HI_LSB +: 8],
					pop_word[`LPP_GRN_HI_LSB + 6 +: 2]};
				next_blu = {pop_word[`LPP_BLU_HI_LSB +: 8],
					pop_word[`LPP_BLU_HI_LSB + 6 +: 2]};
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			red_out        <= '0;
			grn_out        <= '0;
			blu_out        <= '0;
			pix_valid_out  <= 1'b0;
			depth_deep_out <= `LPP_DEPTH_RST;
		end else begin
			red_out        <= next_red;
			grn_out        <= next_grn;
			blu_out        <= next_blu;
			pix_valid_out  <= next_pix_valid;
			depth_deep_out <= depth_deep;
		end
	end

	// Checking helpers
	logic                   chk_pop;
	logic                   chk_deep;
	logic [`LPP_WORD_W-1:0] chk_word;

	always_ff @(posedge clk_sys_in) begin
		chk_pop  <= pop && !sys_rst_in;
		chk_deep <= pop_deep;
		chk_word <= pop_word;
	end

	a_word_per_pixel: assert property (
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		pop |=> pix_valid_out
	) else $error("popped word did not yield a pixel");

	a_deep_high_bytes: assert property (
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		chk_pop && chk_deep |-> red_out[9:2] == chk_word[7:0]
			&& grn_out[9:2] == chk_word[15:8]
			&& blu_out[9:2] == chk_word[23:16]
	) else $error("four-byte high bits misplaced");

	a_deep_low_bits: assert property (
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		chk_pop && chk_deep |-> blu_out[1:0] == chk_word[27:26]
			&& grn_out[1:0] == chk_word[29:28]
			&& red_out[1:0] == chk_word[31:30]
	) else $error("four-byte low bits misplaced");

	a_shallow_bytes: assert property (
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		chk_pop && !chk_deep |-> red_out[9:2] == chk_word[7:0]
			&& grn_out[9:2] == chk_word[15:8]
			&& blu_out[9:2] == chk_word[23:16]
	) else $error("three-byte colour bytes misplaced");

	a_grey_monotone: assert property (
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		chk_pop && !chk_deep |-> red_out[1:0] == red_out[9:8]
			&& grn_out[1:0] == grn_out[9:8]
			&& blu_out[1:0] == blu_out[9:8]
	) else $error("8-bit expansion not monotone");

	a_depth_follow: assert property (
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		st == LPP_ST_VBLANK ##1 st == LPP_ST_VBLANK
			|-> depth_deep == $past(depth_s2)
	) else $error("depth select not taken in vertical blank");

	a_depth_boundary: assert property (
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		$changed(depth_deep) |-> $past(st) == LPP_ST_VBLANK
	) else $error("depth changed inside a frame");

	a_frame_by_window: assert property (
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		!pixel_valid_window_in [*2] |=> st != LPP_ST_LINE
	) else $error("line state without valid window");

	a_supply_off_quiet: assert property (
		@(posedge clk_sys_in) disable iff (sys_rst_in)
		!supply_s2 && !rd_s.valid |=> !rd_s.valid
	) else $error("word taken while panel supply off");
endmodule : lpp_unpacker
`default_nettype wire

// File: lpp_regs.svh
// Constants for the lane pixel unpacker
// Operation
// - 10 or 8 bit grey, larger is brighter
// - 30bpp four bytes, 24bpp three bytes
// - four-byte low bytes hold colour bits 9..2
// - byte three: ignored, blue, green, red bits 1..0
// - three-byte mode bytes hold colour bits 7..0
// - depth select high or open 10-bit, low 8-bit
// - framing by valid window only, syncs ignored
`ifndef LPP_REGS_SVH
`define LPP_REGS_SVH
`define LPP_WORD_W      32
`define LPP_COLOR_W     10
`define LPP_FIFO_DEPTH  32
`define LPP_RED_HI_LSB  0
`define LPP_GRN_HI_LSB  8
`define LPP_BLU_HI_LSB  16
`define LPP_BLU_LO_LSB  26
`define LPP_GRN_LO_LSB  28
`define LPP_RED_LO_LSB  30
`define LPP_HBLANK_MAX  60
`define LPP_BLANK_CNT_W 7
`define LPP_DEPTH_RST   1'h1
`endif

// File: lpp_pkg.sv
// Types shared by the lane pixel unpacker
package lpp_pkg;
	typedef enum logic [2:0] {
		LPP_ST_LINE   = 3'h1,
		LPP_ST_HBLANK = 3'h2,
		LPP_ST_VBLANK = 3'h4
	} lpp_frame_t;
endpackage : lpp_pkg

// File: lpp_stream_if.sv
// Valid/ready stream carrier between unpacker and its FIFO
`timescale 1ns/1ps
`default_nettype none
interface lpp_stream_if #(parameter int WIDTH = 33);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : lpp_stream_if
`default_nettype wire

// File: lpp_fifo.sv
// Lane word FIFO with registered write-side ready
`timescale 1ns/1ps
`default_nettype none
module lpp_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic  clk_sys_in,
	input  wire logic  sys_rst_in,
	// Streams
	lpp_stream_if.snk  wr,
	lpp_stream_if.src  rd
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [CW-1:0]    count;
	logic             in_ready;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [CW-1:0]    next_count;
	logic             next_in_ready;
	logic             push;
	logic             pop;

	assign wr.ready = in_ready;
	assign rd.valid = (count != '0);
	assign rd.data  = mem[rd_ptr];
	assign push     = wr.valid && in_ready;
	assign pop      = rd.valid && rd.ready;

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (push) begin
			next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
		// Registered from the next count so the host sees a clean level
		next_in_ready = (next_count < FULL);
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			wr_ptr   <= '0;
			rd_ptr   <= '0;
			count    <= '0;
			in_ready <= 1'b0;
		end else begin
			wr_ptr   <= next_wr_ptr;
			rd_ptr   <= next_rd_ptr;
			count    <= next_count;
			in_ready <= next_in_ready;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem[wr_ptr] <= wr.data;
		end
	end
endmodule : lpp_fifo
`default_nettype wire

// File: lpp_host_model.sv
// Host video source model driving lane words into the unpacker
`timescale 1ns/1ps
`default_nettype none
module lpp_host_model #(
	parameter int OFF_CYCLES = 20
) (
	// Clock and flow control
	input  wire logic        clk_sys_in,
	input  wire logic        lane_ready_in,
	// Lines into the panel
	output logic             supply_out,
	output logic             valid_out,
	output logic [31:0]      word_out
);
	initial begin
		supply_out = 1'h0;
		valid_out = 1'h0;
		word_out = 32'h0;
	end
	// Idle data toggles while the supply is on, and is held at zero while it is off, so a stale word is never mistaken for data
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk_sys_in);
			#1;
			valid_out = 1'h0;
			word_out = supply_out ? ~word_out : 32'h0;
		end
	endtask : idle
	task automatic send(input logic [31:0] w, output logic taken);
		@(posedge clk_sys_in);
		#1;
		valid_out = 1'h1;
		word_out = w;
		taken = lane_ready_in;
	endtask : send
	// Off time shortened from 1.0 s to keep the run short
	task automatic power(input logic on);
		@(posedge clk_sys_in);
		#1;
		valid_out = 1'h0;
		word_out = 32'h0;
		supply_out = on;
		repeat (on ? 3 : OFF_CYCLES) @(posedge clk_sys_in);
	endtask : power
endmodule : lpp_host_model
`default_nettype wire

// File: lane_pixel_packer_test.sv
// Self-checking testbench for the lane pixel unpacker
`timescale 1ns/1ps
`default_nettype none
module lane_pixel_packer_test;
	logic        clk_sys_in;
	logic        sys_rst_in;
	logic        depth_sel_in;
	logic        pix_ready_in;
	logic        cur_deep = 1'h1;
	logic        supply;
	logic        valid;
	logic        lane_ready_out;
	logic        pix_valid_out;
	logic        depth_deep_out;
	logic [31:0] word;
	logic [9:0]  red_out;
	logic [9:0]  grn_out;
	logic [9:0]  blu_out;
	logic [32:0] q[$];
	int          fails = 0;
	int          tests_run = 0;

	always #50 clk_sys_in = ~clk_sys_in;

	lpp_host_model u_host (.clk_sys_in(clk_sys_in),
		.lane_ready_in(lane_ready_out), .supply_out(supply),
		.valid_out(valid), .word_out(word));
	lpp_unpacker u_dut (.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in), .depth_sel_in(depth_sel_in),
		.panel_logic_supply_in(supply), .lane_word_in(word),
		.pixel_valid_window_in(valid), .lane_ready_out(lane_ready_out),
		.red_out(red_out), .grn_out(grn_out), .blu_out(blu_out),
		.pix_valid_out(pix_valid_out), .pix_ready_in(pix_ready_in),
		.depth_deep_out(depth_deep_out));

	function automatic logic [29:0] unpack(input logic [32:0] e);
		if (e[32])
			return {e[7:0], e[31:30], e[15:8], e[29:28], e[23:16], e[27:26]};
		return {e[7:0], e[7:6], e[15:8], e[15:14], e[23:16], e[23:22]};
	endfunction : unpack

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Only words seen taken are expected; refused ones are lost
	task automatic push(input int n, input int seed);
		logic [31:0] w;
		logic        tk;
		for (int i = 0; i < n; i++) begin
			w = 32'(i + seed) * 32'h9E3779B9;
			u_host.send(w, tk);
			if (tk === 1'h1)
				q.push_back({cur_deep, w});
		end
		u_host.idle(1);
	endtask : push

	task automatic drain;
		@(posedge clk_sys_in);
		#1;
		pix_ready_in = 1'h1;
		for (int i = 0; i < 80 && q.size() > 0; i++) begin
			if (pix_valid_out === 1'h1)
				check({2'h0, red_out, grn_out, blu_out},
					{2'h0, unpack(q.pop_front())});
			@(posedge clk_sys_in);
			#1;
		end
		pix_ready_in = 1'h0;
		check(32'(q.size()), 32'h0);
	endtask : drain

	task automatic depth_to(input logic pin, input int n, input logic exp);
		@(posedge clk_sys_in);
		#1;
		depth_sel_in = pin;
		u_host.idle(n);
		check({31'h0, depth_deep_out}, {31'h0, exp});
	endtask : depth_to

	// Downstream stalls so the FIFO fills until it refuses
	task automatic t_fill;
		push(40, 1);
		check({31'h0, lane_ready_out}, 32'h0);
		check({31'h0, q.size() > 31}, 32'h1);
		drain();
		$display("done fill");
	endtask : t_fill

	task automatic t_narrow;
		depth_to(1'h0, 70, 1'h0);
		cur_deep = 1'h0;
		push(5, 50);
		drain();
		$display("done narrow");
	endtask : t_narrow

	// A pin change inside a frame must wait for vertical blank
	task automatic t_midframe;
		push(3, 60);
		depth_to(1'h1, 10, 1'h0);
		push(3, 70);
		drain();
		depth_to(1'h1, 70, 1'h1);
		cur_deep = 1'h1;
		push(3, 80);
		drain();
		$display("done midframe");
	endtask : t_midframe

	task automatic t_supply;
		logic tk;
		u_host.power(1'h0);
		u_host.send(32'hFFFF_FFFF, tk);
		u_host.idle(8);
		check({31'h0, pix_valid_out}, 32'h0);
		u_host.power(1'h1);
		push(4, 90);
		drain();
		$display("done supply");
	endtask : t_supply

	task automatic results;
		$display("tests %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	initial begin
		clk_sys_in = 1'h0;
		sys_rst_in = 1'h1;
		depth_sel_in = 1'h1;
		pix_ready_in = 1'h0;
		repeat (10) @(posedge clk_sys_in);
		#1;
		sys_rst_in = 1'h0;
		u_host.power(1'h1);
		t_fill();
		t_narrow();
		t_midframe();
		t_supply();
		results();
	end

	initial begin
		repeat (5000) @(posedge clk_sys_in);
		fails++;
		results();
	end
endmodule : lane_pixel_packer_test
`default_nettype wire
